// File: rtl/uhbrp_buffer_port.sv
// host buffer RAM access through command and data port registers
// Function
// RL1 - outgoing payload directly follows its descriptor
// RL2 - incoming descriptor reserves total byte count space
// RL3 - descriptors and payloads start four-byte aligned
// RL4 - iso port read 40H, write C0H
// RL5 - ack port read 41H, write C1H
// RL6 - each port access moves two bytes
// RL7 - low byte even address, high byte odd
// RL8 - command issued once, then many data accesses
// RL9 - pointer equals counter sets end flag bit2
// RL10 - end event updates status, ack full bit2
// RL11 - iso halves swap at every frame start
// RL12 - both halves full: no swap, second half
// RL13 - device steers iso port to correct half
// RL14 - processed ack list sets done bit5
// RL15 - processed ack list sets interrupt bit1
// RL16 - not operational: no traffic, done flags zero
// RL17 - both iso halves have equal size
// RL18 - iso read clears full and done flags
// RL19 - new command restarts pointer at area start
// RL20 - writing one clears an interrupt flag
`timescale 1ns/1ps
`include "uhbrp_params.svh"
module uhbrp_buffer_port
   import uhbrp_pkg::*;
#(
   parameter int RAM_BYTES = `UHBRP_RAM_BYTES,
   parameter int AW        = `UHBRP_ADDR_BITS
) (
   // clock, reset, enable
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          clkEn,
   // processor command and data port
   input  wire logic          cmdWr,
   input  wire logic [7:0]    cmdCode,
   input  wire logic          dataWr,
   input  wire logic          dataRd,
   input  wire logic [15:0]   dataIn,
   output logic      [15:0]   dataOut,
   output logic               rdValid,
   // controller state and frame timing
   input  wire logic          hcOperational,
   input  wire logic          sofPulse,
   // controller list handshake
   output logic               atlGo,
   input  wire logic          atlDone,
   input  wire logic          isoDone,
   output logic      [AW-1:0] isoCtlBase,
   // controller byte access to the RAM
   input  wire logic [AW-1:0] ctlAddr,
   input  wire logic          ctlWe,
   input  wire logic [7:0]    ctlWdata,
   output logic      [7:0]    ctlRdata
);

   localparam logic [15:0] STEP = `UHBRP_PORT_STEP;

   logic [7:0]       cmd_q;
   logic [6:0]       idx;
   logic             wrCmd;
   logic             isoSel;
   logic             ackSel;
   logic             portAcc;
   logic             regWr;
   logic [15:0]      ptr_q;
   logic [15:0]      ptrNext;
   logic             transfer_end_event;
   logic [15:0]      xferCnt_q;
   logic [15:0]      ackLen_q;
   logic [15:0]      isoLen_q;
   logic             irqAck_q;
   logic             irqEnd_q;
   logic             ackFull_q;
   logic             ackDone_q;
   logic [1:0]       isoFull_q;
   logic [1:0]       isoDone_q;
   logic [15:0]      statusWord;
   logic [15:0]      irqWord;
   uhbrp_half_t      cpuHalf;
   logic             cpuHalfIdx;
   logic [AW-1:0]    isoCpuBase;
   logic [AW-1:0]    ramCpuAddr;
   logic [15:0]      ramRdata;
   logic             ackSet;
   logic             ackClr;
   logic             atlGo_q;
   uhbrp_ack_state_t ackState_q;
   logic [15:0]      dataOut_q;
   logic             rdValid_q;

   // true for an index that opens a buffer access port
   function automatic logic isPort(input logic [6:0] code);
      return (code == `UHBRP_IDX_ISO_PORT) || (code == `UHBRP_IDX_ACK_PORT);
   endfunction

   // latch the command byte, it stays for all following data accesses
   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_q <= 8'h00;
      end else if (clkEn && cmdWr) begin
         cmd_q <= cmdCode; // RL8
      end
   end

   // command decode
   assign idx     = cmd_q[6:0];
   assign wrCmd   = cmd_q[`UHBRP_WR_BIT];
   assign isoSel  = (idx == `UHBRP_IDX_ISO_PORT); // RL4
   assign ackSel  = (idx == `UHBRP_IDX_ACK_PORT); // RL5
   assign portAcc = !cmdWr && isPort(idx) && ((dataWr && wrCmd) || (dataRd && !wrCmd));
   assign regWr   = !cmdWr && !isPort(idx) && dataWr && wrCmd;
   assign ptrNext = ptr_q + STEP;
   assign transfer_end_event     = portAcc && (ptrNext == xferCnt_q); // RL9

   // buffer pointer, two bytes per port access
   always_ff @(posedge clock) begin
      if (rst) begin
         ptr_q <= `UHBRP_RST_WORD;
      end else if (clkEn) begin
         if (cmdWr) begin
            ptr_q <= `UHBRP_RST_WORD; // RL19
         end else if (portAcc) begin
            ptr_q <= ptrNext; // RL6
         end
      end
   end

   // programmed counter and lengths
   always_ff @(posedge clock) begin
      if (rst) begin
         xferCnt_q <= `UHBRP_RST_WORD;
         ackLen_q  <= `UHBRP_RST_WORD;
         isoLen_q  <= `UHBRP_RST_WORD;
      end else if (clkEn && regWr) begin
         if (idx == `UHBRP_IDX_XFER_CNT) begin
            xferCnt_q <= dataIn;
         end
         if (idx == `UHBRP_IDX_ACK_LEN) begin
            ackLen_q <= dataIn;
         end
         if (idx == `UHBRP_IDX_ISO_LEN) begin
            isoLen_q <= dataIn;
         end
      end
   end

   // iso half selection and area bases
   uhbrp_iso_pingpong #(
      .AW       (AW)
   ) u_pingpong (
      .clock    (clock),
      .rst      (rst),
      .clkEn    (clkEn),
      .sofPulse (sofPulse),
      .bothFull (&isoFull_q),
      .ackLen   (ackLen_q),
      .isoLen   (isoLen_q),
      .cpuHalf  (cpuHalf),
      .cpuBase  (isoCpuBase),
      .ctlBase  (isoCtlBase)
   );

   assign cpuHalfIdx = (cpuHalf == HALF_SECOND);

   // iso port lands in the processor's half, ack port at RAM start
   assign ramCpuAddr = (isoSel ? isoCpuBase : '0) + ptr_q[AW-1:0]; // RL13

   // buffer RAM
   uhbrp_byte_ram #(
      .BYTES    (RAM_BYTES),
      .AW       (AW)
   ) u_ram (
      .clock    (clock),
      .clkEn    (clkEn),
      .cpuAddr  (ramCpuAddr),
      .cpuWe    (portAcc && wrCmd),
      .cpuWdata (dataIn),
      .cpuRdata (ramRdata),
      .ctlAddr  (ctlAddr),
      .ctlWe    (ctlWe),
      .ctlWdata (ctlWdata),
      .ctlRdata (ctlRdata)
   );

   // ack list processing, only in operational state
   always_ff @(posedge clock) begin
      if (rst) begin
         ackState_q <= ACK_IDLE;
         atlGo_q    <= 1'b0;
      end else if (clkEn) begin
         atlGo_q <= 1'b0;
         unique case (ackState_q)
            ACK_IDLE: begin
               if (hcOperational && ackFull_q && !ackDone_q) begin // RL16
                  ackState_q <= ACK_BUSY;
                  atlGo_q    <= 1'b1;
               end
            end
            ACK_BUSY: begin
               if (atlDone || !hcOperational) begin
                  ackState_q <= ACK_IDLE;
               end
            end
         endcase
      end
   end

   assign atlGo  = atlGo_q && clkEn;
   assign ackSet = clkEn && (ackState_q == ACK_BUSY) && atlDone && hcOperational;
   assign ackClr = transfer_end_event && ackSel && !wrCmd;

   // ack full and done, set wins over clear
   always_ff @(posedge clock) begin
      if (rst) begin
         ackFull_q <= 1'b0;
         ackDone_q <= 1'b0;
      end else if (clkEn) begin
         ackFull_q <= (ackFull_q && !ackClr) || (transfer_end_event && ackSel && wrCmd); // RL10
         ackDone_q <= (ackDone_q && !ackClr) || ackSet; // RL14
      end
   end

   // iso full and done per half, a read of the half clears both
   always_ff @(posedge clock) begin
      if (rst) begin
         isoFull_q <= 2'h0;
         isoDone_q <= 2'h0;
      end else if (clkEn) begin
         if (portAcc && isoSel && !wrCmd) begin
            isoFull_q[cpuHalfIdx] <= 1'b0; // RL18
            isoDone_q[cpuHalfIdx] <= 1'b0; // RL18
         end
         if (transfer_end_event && isoSel && wrCmd) begin
            isoFull_q[cpuHalfIdx] <= 1'b1; // RL10
         end
         if (isoDone && hcOperational) begin
            isoDone_q[!cpuHalfIdx] <= 1'b1;
         end
      end
   end

   // interrupt flags, write one to clear, set wins
   always_ff @(posedge clock) begin
      if (rst) begin
         irqAck_q <= 1'b0;
         irqEnd_q <= 1'b0;
      end else if (clkEn) begin
         irqAck_q <= (irqAck_q && !(regWr && (idx == `UHBRP_IDX_IRQ)
                     && dataIn[`UHBRP_IRQ_ACK])) || ackSet; // RL15
         irqEnd_q <= (irqEnd_q && !(regWr && (idx == `UHBRP_IDX_IRQ)
                     && dataIn[`UHBRP_IRQ_END])) || transfer_end_event; // RL20
      end
   end

   // readable status words
   always_comb begin
      statusWord                        = `UHBRP_RST_WORD;
      statusWord[`UHBRP_ST_ISO0_FULL]   = isoFull_q[0];
      statusWord[`UHBRP_ST_ISO1_FULL]   = isoFull_q[1];
      statusWord[`UHBRP_ST_ACK_FULL]    = ackFull_q;
      statusWord[`UHBRP_ST_ISO0_DONE]   = isoDone_q[0];
      statusWord[`UHBRP_ST_ISO1_DONE]   = isoDone_q[1];
      statusWord[`UHBRP_ST_ACK_DONE]    = ackDone_q;
      irqWord                           = `UHBRP_RST_WORD;
      irqWord[`UHBRP_IRQ_ACK]           = irqAck_q;
      irqWord[`UHBRP_IRQ_END]           = irqEnd_q;
   end

   // read data register, one cycle after the read strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         dataOut_q <= `UHBRP_RST_WORD;
         rdValid_q <= 1'b0;
      end else if (clkEn) begin
         rdValid_q <= dataRd && !cmdWr && !wrCmd;
         if (dataRd && !cmdWr && !wrCmd) begin
            if (isPort(idx)) begin
               dataOut_q <= ramRdata; // RL7
            end else begin
               unique case (idx)
                  `UHBRP_IDX_XFER_CNT: dataOut_q <= xferCnt_q;
                  `UHBRP_IDX_IRQ:      dataOut_q <= irqWord;
                  `UHBRP_IDX_ISO_LEN:  dataOut_q <= isoLen_q;
                  `UHBRP_IDX_ACK_LEN:  dataOut_q <= ackLen_q;
                  `UHBRP_IDX_STATUS:   dataOut_q <= statusWord;
                  default:             dataOut_q <= `UHBRP_RST_WORD;
               endcase
            end
         end
      end
   end

   assign dataOut = dataOut_q;
   assign rdValid = rdValid_q;

   // checks on pointer, flags and ping-pong
   property p_ptr_step;
      @(posedge clock) disable iff (rst)
      clkEn && portAcc |=> ptr_q == $past(ptr_q) + STEP;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step by two"); // RL6

   property p_cmd_restart;
      @(posedge clock) disable iff (rst)
      clkEn && cmdWr |=> ptr_q == `UHBRP_RST_WORD;
   endproperty
   a_cmd_restart: assert property (p_cmd_restart) else $error("pointer not restarted"); // RL19

   property p_end_flag;
      @(posedge clock) disable iff (rst)
      clkEn && portAcc && (ptrNext == xferCnt_q) |=> irqWord[`UHBRP_IRQ_END];
   endproperty
   a_end_flag: assert property (p_end_flag) else $error("end flag not set"); // RL9

   property p_ack_full;
      @(posedge clock) disable iff (rst)
      clkEn && transfer_end_event && ackSel && wrCmd |=> statusWord[`UHBRP_ST_ACK_FULL] ##1 1'b1;
   endproperty
   a_ack_full: assert property (p_ack_full) else $error("ack full not set"); // RL10

   property p_iso_swap;
      @(posedge clock) disable iff (rst)
      clkEn && sofPulse && !(&isoFull_q) |=> cpuHalf != $past(cpuHalf);
   endproperty
   a_iso_swap: assert property (p_iso_swap) else $error("iso halves not swapped"); // RL11

   property p_iso_hold;
      @(posedge clock) disable iff (rst)
      clkEn && sofPulse && (&isoFull_q) |=> cpuHalf == HALF_SECOND;
   endproperty
   a_iso_hold: assert property (p_iso_hold) else $error("full halves not held"); // RL12

   property p_ack_done;
      @(posedge clock) disable iff (rst)
      ackSet |=> statusWord[`UHBRP_ST_ACK_DONE] && irqWord[`UHBRP_IRQ_ACK];
   endproperty
   a_ack_done: assert property (p_ack_done) else $error("ack done not flagged"); // RL14 RL15

   property p_idle_quiet;
      @(posedge clock) disable iff (rst)
      !hcOperational && !ackDone_q && !irqAck_q |=> !ackDone_q && !irqAck_q && !atlGo_q;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle"); // RL16

   property p_irq_clear;
      @(posedge clock) disable iff (rst)
      clkEn && regWr && (idx == `UHBRP_IDX_IRQ) && dataIn[`UHBRP_IRQ_END]
      |=> !irqEnd_q;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("end flag not cleared"); // RL20

   property p_iso_read_clear;
      @(posedge clock) disable iff (rst)
      clkEn && portAcc && isoSel && !wrCmd && (cpuHalf == HALF_FIRST) && !isoDone
      |=> !isoFull_q[0] && !isoDone_q[0];
   endproperty
   a_iso_read_clear: assert property (p_iso_read_clear) else $error("iso flags kept"); // RL18

   c_eot: cover property (@(posedge clock) disable iff (rst) clkEn && transfer_end_event && ackSel);
   c_swap: cover property (@(posedge clock) disable iff (rst) clkEn && sofPulse);
   c_ack_done: cover property (@(posedge clock) disable iff (rst) ackSet);

endmodule // uhbrp_buffer_port

// File: rtl/uhbrp_params.svh
// constants of the host buffer RAM access port
`ifndef UHBRP_PARAMS_SVH
`define UHBRP_PARAMS_SVH

// command byte: bit 7 marks a write, bits 6:0 are the register index
`define UHBRP_WR_BIT        7
`define UHBRP_IDX_XFER_CNT  7'h22
`define UHBRP_IDX_IRQ       7'h24
`define UHBRP_IDX_ISO_LEN   7'h2A
`define UHBRP_IDX_ACK_LEN   7'h2B
`define UHBRP_IDX_STATUS    7'h2C
`define UHBRP_IDX_ISO_PORT  7'h40
`define UHBRP_IDX_ACK_PORT  7'h41

// interrupt flag bit positions
`define UHBRP_IRQ_ACK       1
`define UHBRP_IRQ_END       2

// buffer status bit positions
`define UHBRP_ST_ISO0_FULL  0
`define UHBRP_ST_ISO1_FULL  1
`define UHBRP_ST_ACK_FULL   2
`define UHBRP_ST_ISO0_DONE  3
`define UHBRP_ST_ISO1_DONE  4
`define UHBRP_ST_ACK_DONE   5

// sizes, steps and reset values
`define UHBRP_RAM_BYTES     4096
`define UHBRP_ADDR_BITS     12
`define UHBRP_PORT_STEP     16'h0002
`define UHBRP_ALIGN_ROUND   16'h0003
`define UHBRP_RST_WORD      16'h0000

`endif

// File: rtl/uhbrp_pkg.sv
// types of the host buffer RAM access port
package uhbrp_pkg;

   // which ping-pong half
   typedef enum logic {
      HALF_FIRST,
      HALF_SECOND
   } uhbrp_half_t;

   // acknowledged list processing handshake
   typedef enum logic {
      ACK_IDLE,
      ACK_BUSY
   } uhbrp_ack_state_t;

endpackage

// File: rtl/uhbrp_byte_ram.sv
// byte-organised buffer RAM with a word port and a byte port
`timescale 1ns/1ps
`include "uhbrp_params.svh"
module uhbrp_byte_ram #(
   parameter int BYTES = `UHBRP_RAM_BYTES,
   parameter int AW    = `UHBRP_ADDR_BITS
) (
   // clock
   input  wire logic          clock,
   input  wire logic          clkEn,
   // processor word port
   input  wire logic [AW-1:0] cpuAddr,
   input  wire logic          cpuWe,
   input  wire logic [15:0]   cpuWdata,
   output logic      [15:0]   cpuRdata,
   // controller byte port
   input  wire logic [AW-1:0] ctlAddr,
   input  wire logic          ctlWe,
   input  wire logic [7:0]    ctlWdata,
   output logic      [7:0]    ctlRdata
);

   logic [7:0] evenMem [BYTES/2];
   logic [7:0] oddMem  [BYTES/2];

   // even lane, both ports write; processor last so it wins a same-byte collision
   always_ff @(posedge clock) begin
      if (clkEn && ctlWe && !ctlAddr[0]) begin
         evenMem[ctlAddr[AW-1:1]] <= ctlWdata;
      end
      if (clkEn && cpuWe) begin
         evenMem[cpuAddr[AW-1:1]] <= cpuWdata[7:0]; // RL7
      end
   end

   // odd lane, same ordering
   always_ff @(posedge clock) begin
      if (clkEn && ctlWe && ctlAddr[0]) begin
         oddMem[ctlAddr[AW-1:1]] <= ctlWdata;
      end
      if (clkEn && cpuWe) begin
         oddMem[cpuAddr[AW-1:1]] <= cpuWdata[15:8]; // RL7
      end
   end

   // low byte from the even address, high byte from the odd one
   assign cpuRdata = {oddMem[cpuAddr[AW-1:1]], evenMem[cpuAddr[AW-1:1]]};
   assign ctlRdata = ctlAddr[0] ? oddMem[ctlAddr[AW-1:1]] : evenMem[ctlAddr[AW-1:1]];

endmodule // uhbrp_byte_ram

// File: rtl/uhbrp_iso_pingpong.sv
// iso ping-pong half selection and area bases
`timescale 1ns/1ps
`include "uhbrp_params.svh"
module uhbrp_iso_pingpong
   import uhbrp_pkg::*;
#(
   parameter int AW = `UHBRP_ADDR_BITS
) (
   // clock, reset, enable
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          clkEn,
   // frame and fill state
   input  wire logic          sofPulse,
   input  wire logic          bothFull,
   // programmed lengths
   input  wire logic [15:0]   ackLen,
   input  wire logic [15:0]   isoLen,
   // selection
   output uhbrp_half_t        cpuHalf,
   output logic      [AW-1:0] cpuBase,
   output logic      [AW-1:0] ctlBase
);

   logic [AW-1:0] firstBase;
   logic [AW-1:0] secondBase;

   // round a length up to a four-byte boundary
   function automatic logic [AW-1:0] alignUp(input logic [15:0] len);
      logic [15:0] r;
      r = (len + `UHBRP_ALIGN_ROUND) & ~`UHBRP_ALIGN_ROUND;
      return r[AW-1:0];
   endfunction

   // iso halves follow the ack area, both of one size
   assign firstBase  = alignUp(ackLen); // RL3
   assign secondBase = firstBase + alignUp(isoLen); // RL17

   // swap at each frame start unless both halves are full
   always_ff @(posedge clock) begin
      if (rst) begin
         cpuHalf <= HALF_FIRST;
      end else if (clkEn && sofPulse) begin
         if (bothFull) begin
            cpuHalf <= HALF_SECOND; // RL12
         end else begin
            cpuHalf <= (cpuHalf == HALF_FIRST) ? HALF_SECOND : HALF_FIRST; // RL11
         end
      end
   end

   // processor and controller always sit on opposite halves
   assign cpuBase = (cpuHalf == HALF_SECOND) ? secondBase : firstBase;
   assign ctlBase = (cpuHalf == HALF_SECOND) ? firstBase : secondBase;

endmodule // uhbrp_iso_pingpong

// File: tb/uhbrp_ctl_model.sv
// controller-side model: answers list requests and peeks the buffer RAM
`timescale 1ns/1ps
module uhbrp_ctl_model #(
   parameter int AW    = 12,
   parameter int DELAY = 6
) (
   // clock, reset
   input  wire logic          clock,
   input  wire logic          rst,
   // list handshake
   input  wire logic          atlGo,
   output logic               atlDone,
   input  wire logic          isoKick,
   output logic               isoDone,
   // byte access
   input  wire logic [AW-1:0] peekAddr,
   output logic      [AW-1:0] ctlAddr,
   output logic               ctlWe,
   output logic      [7:0]    ctlWdata
);
   int waitCnt;

   // byte port peeks for the bench, and stores one received byte late in a list run
   assign ctlWe    = (waitCnt == 1);
   assign ctlAddr  = ctlWe ? AW'(3) : peekAddr;
   assign ctlWdata = 8'hC3;

   // list done after a delay, iso done one cycle after a kick
   always_ff @(posedge clock) begin
      if (rst) begin
         waitCnt <= 0;
         atlDone <= 1'b0;
         isoDone <= 1'b0;
      end else begin
         isoDone <= isoKick;
         atlDone <= (waitCnt == 1);
         if (atlGo)
            waitCnt <= DELAY;
         else if (waitCnt > 0)
            waitCnt <= waitCnt - 1;
      end
   end
endmodule // uhbrp_ctl_model

// File: tb/usb_host_buffer_ram_port_bench.sv
// self-checking bench for the host buffer RAM access port
`timescale 1ns/1ps
module usb_host_buffer_ram_port_bench;
   logic        clock, rst, cmdWr, dataWr, dataRd, hcOperational, sofPulse, isoKick, clkEn;
   logic        rdValid, atlGo, atlDone, isoDone, ctlWe;
   logic [7:0]  cmdCode, ctlWdata, ctlRdata;
   logic [15:0] dataIn, dataOut;
   logic [11:0] isoCtlBase, ctlAddr, peekAddr;
   int          miscompares, num_checks, goCount, doneCount;

   // design under test
   uhbrp_buffer_port u_dut (
      .clock(clock), .rst(rst), .clkEn(clkEn), .cmdWr(cmdWr), .cmdCode(cmdCode),
      .dataWr(dataWr), .dataRd(dataRd), .dataIn(dataIn), .dataOut(dataOut),
      .rdValid(rdValid), .hcOperational(hcOperational), .sofPulse(sofPulse),
      .atlGo(atlGo), .atlDone(atlDone), .isoDone(isoDone), .isoCtlBase(isoCtlBase),
      .ctlAddr(ctlAddr), .ctlWe(ctlWe), .ctlWdata(ctlWdata), .ctlRdata(ctlRdata));

   // controller side
   uhbrp_ctl_model u_ctl (
      .clock(clock), .rst(rst), .atlGo(atlGo), .atlDone(atlDone), .isoKick(isoKick),
      .isoDone(isoDone), .peekAddr(peekAddr), .ctlAddr(ctlAddr), .ctlWe(ctlWe),
      .ctlWdata(ctlWdata));

   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // count list requests and answers
   always @(posedge clock) begin
      if (atlGo === 1'b1)
         goCount++;
      if (atlDone === 1'b1)
         doneCount++;
   end

   function automatic logic [15:0] pat(input logic [7:0] s, input int i);
      return {s + 8'(2 * i + 1), s + 8'(2 * i)};
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic cmd(input logic [7:0] code);
      @(negedge clock);
      cmdWr   = 1'b1;
      cmdCode = code;
      @(negedge clock);
      cmdWr   = 1'b0;
   endtask

   // words sent back to back with the strobe held
   task automatic wrSeq(input logic [7:0] seed, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         dataWr = 1'b1;
         dataIn = pat(seed, i);
      end
      @(negedge clock);
      dataWr = 1'b0;
   endtask

   // one read: answer one edge after the strobe
   task automatic rdOne(input string what, input logic [15:0] exp);
      @(negedge clock);
      dataRd = 1'b1;
      @(negedge clock);
      dataRd = 1'b0;
      check(what, {1'b1, exp}, {rdValid, dataOut});
   endtask

   task automatic rdSeq(input string what, input logic [7:0] seed, input int n);
      for (int i = 0; i < n; i++)
         rdOne(what, pat(seed, i));
   endtask

   task automatic regRd(input string what, input logic [7:0] idx, input logic [15:0] exp);
      cmd(idx);
      rdOne(what, exp);
   endtask

   task automatic regWr(input logic [7:0] idx, input logic [15:0] val);
      cmd(idx | 8'h80);
      @(negedge clock);
      dataWr = 1'b1;
      dataIn = val;
      @(negedge clock);
      dataWr = 1'b0;
   endtask

   task automatic peek(input logic [11:0] a, input logic [7:0] exp, input string what);
      @(negedge clock);
      peekAddr = a;
      #10;
      check(what, {9'h000, exp}, {9'h000, ctlRdata});
   endtask

   task automatic frameEvt(input bit iso);
      @(negedge clock);
      if (iso)
         isoKick = 1'b1;
      else
         sofPulse = 1'b1;
      @(negedge clock);
      isoKick  = 1'b0;
      sofPulse = 1'b0;
   endtask

   task automatic waitDone();
      for (int k = 0; k < 100 && doneCount == 0; k++)
         @(negedge clock);
      if (doneCount == 0) begin
         miscompares++;
         $display("wrong value list answer expected 1 seen 0");
         end_of_test();
      end
      repeat (2) @(negedge clock);
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      {cmdWr, dataWr, dataRd, hcOperational, sofPulse, isoKick} = 6'h00;
      cmdCode = 8'h00;
      dataIn = 16'h0000;
      peekAddr = 12'h000;
      clkEn = 1'b1;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      // reset values, unmapped index, read-only status
      regRd("counter", 8'h22, 16'h0000);
      regRd("irq", 8'h24, 16'h0000);
      regRd("ack len", 8'h2B, 16'h0000);
      regRd("unmapped", 8'h30, 16'h0000);
      regWr(8'hAC, 16'hFFFF);
      regRd("status", 8'h2C, 16'h0000);
      // a write made while the enable is low must leave no trace
      clkEn = 1'b0;
      regWr(8'hA2, 16'h1234);
      clkEn = 1'b1;
      regRd("frozen counter", 8'h22, 16'h0000);
      check("iso base", 17'h00000, {5'h00, isoCtlBase});
      done("reset");
      // ack list written while not operational
      regWr(8'hA4, 16'h0004);
      regWr(8'hAB, 16'h1000);
      regWr(8'hA2, 16'h0008);
      regRd("counter", 8'h22, 16'h0008);
      cmd(8'hC1);
      wrSeq(8'h10, 4);
      regRd("irq end", 8'h24, 16'h0004);
      regRd("status full", 8'h2C, 16'h0004);
      check("list requests", 17'h00000, 17'(goCount));
      peek(12'h000, 8'h10, "byte 0");
      peek(12'h001, 8'h11, "byte 1");
      peek(12'h006, 8'h16, "byte 6");
      regWr(8'hA4, 16'h0004);
      regRd("irq cleared", 8'h24, 16'h0000);
      cmd(8'h41);
      rdSeq("ack word", 8'h10, 4);
      regRd("status read back", 8'h2C, 16'h0000);
      done("offline ack");
      // ack list processed while operational
      hcOperational = 1'b1;
      regWr(8'hA2, 16'h0004);
      cmd(8'hC1);
      wrSeq(8'h40, 2);
      waitDone();
      check("list requests", 17'h00001, 17'(goCount));
      regRd("status done", 8'h2C, 16'h0024);
      regRd("irq list", 8'h24, 16'h0006);
      cmd(8'h41);
      rdOne("ack word", 16'h4140);
      rdOne("ack in byte", 16'hC342);
      regRd("status read back", 8'h2C, 16'h0000);
      regWr(8'hA4, 16'h0006);
      regRd("irq cleared", 8'h24, 16'h0000);
      done("operational ack");
      // iso ping-pong halves
      regWr(8'hAB, 16'h0010);
      regWr(8'hAA, 16'h0010);
      regRd("iso len", 8'h2A, 16'h0010);
      check("iso base", 17'h00020, {5'h00, isoCtlBase});
      cmd(8'hC0);
      wrSeq(8'h80, 2);
      regRd("first full", 8'h2C, 16'h0001);
      frameEvt(1'b0);
      check("iso base swap", 17'h00010, {5'h00, isoCtlBase});
      peek(12'h010, 8'h80, "first half byte");
      cmd(8'hC0);
      wrSeq(8'hA0, 2);
      peek(12'h021, 8'hA1, "second half byte");
      regRd("both full", 8'h2C, 16'h0003);
      frameEvt(1'b0);
      check("iso base held", 17'h00010, {5'h00, isoCtlBase});
      cmd(8'h40);
      rdSeq("second half word", 8'hA0, 1);
      regRd("second cleared", 8'h2C, 16'h0001);
      frameEvt(1'b1);
      regRd("first done", 8'h2C, 16'h0009);
      frameEvt(1'b0);
      check("iso base swap", 17'h00020, {5'h00, isoCtlBase});
      cmd(8'h40);
      rdSeq("first half word", 8'h80, 1);
      regRd("first cleared", 8'h2C, 16'h0000);
      done("iso");
      end_of_test();
   end
endmodule // usb_host_buffer_ram_port_bench
